// File: shared/hpbg_regs_pkg.sv
// Types shared by the host port bus glue
package hpbg_pkg;
    typedef enum logic { HPBG_HALF16, HPBG_FULL32 } hpbg_width_type;
    typedef enum logic [1:0] { HPBG_IDLE, HPBG_FETCH, HPBG_HOLD, HPBG_STORE } hpbg_state_type;
endpackage

// File: shared/hpbg_regs.svh
// Encodings, field positions and reset values of the host port
`ifndef HPBG_REGS_SVH
`define HPBG_REGS_SVH
`define HPBG_SEL_CTRL      2'h0
`define HPBG_SEL_ADDR      2'h1
`define HPBG_SEL_DATA_INC  2'h2
`define HPBG_SEL_DATA_FIX  2'h3
`define HPBG_CTRL_ORDER    0
`define HPBG_CTRL_DSPINT   1
`define HPBG_CTRL_HOSTINT  2
`define HPBG_ADDR_STEP     32'h0000_0004
`define HPBG_ADDR_RESET    32'h0000_0000
`define HPBG_HALF_W        16
`endif

// File: logic/hpbg_strobe.sv
// Combined strobe and select qualifier of the host port
`timescale 1ns/1ns
module hpbg_strobe (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic strobe_a,
    input  wire logic strobe_b,
    input  wire logic select_n,
    output logic      active,
    output logic      start
);
    logic act_reg;
    logic act_next;
    logic prev_reg;
    logic prev_next;
    logic strobe_n;

    always_comb begin
        // Exclusive-NOR of the two strobe pins; low means the strobe is asserted
        strobe_n  = ~(strobe_a ^ strobe_b); // R05
        // The select pin doubles as data strobe
        act_next  = ~select_n & ~strobe_n; // R08
        prev_next = act_reg;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            act_reg  <= 1'b0;
            prev_reg <= 1'b0;
        end else if (ce) begin
            act_reg  <= act_next;
            prev_reg <= prev_next;
        end
    end

    assign active = act_reg;
    assign start  = act_reg & ~prev_reg;

    strobe_xnor_a : assert property (@(posedge clk) disable iff (rst) // R05
        (ce && (strobe_a == strobe_b)) |=> !act_reg)
        else $error("strobe taken with equal strobe inputs");
endmodule

// File: logic/hpbg_host_port.sv
// Host port glue: select-strobed access to control, address and data of internal memory
// Summary of operation
// R01 - Host address bits 3:2 pick which port register a cycle reaches.
// R02 - Host address bit 1 marks first or second halfword, unused in 32-bit mode.
// R03 - The host read/write line sets the direction of each port cycle.
// R04 - The host carries port data on D31:16 in 16-bit mode and D31:0 in 32-bit mode.
// R05 - The port forms its data strobe as the exclusive-NOR of its two strobe inputs.
// R06 - The host holds the first strobe input low and the second high.
// R07 - The host holds the port address strobe inactive high.
// R08 - One host chip-select drives the port select, which acts as the data strobe.
// R09 - The host holds both lane enables low so writes reach both bytes.
// R10 - The host straps its configuration to 101 for 16-bit or 100 for 32-bit mode.
// R11 - Host configuration 10 enables its core with the base register at 0x003FF00.
// R12 - The host acknowledge is the OR of port ready and chip-select.
// R13 - The port interrupt goes to one host interrupt input, level 7 held until acknowledged.
// R14 - The host auto-vector input is held low for interrupt acknowledge cycles.
`timescale 1ns/1ns
`include "hpbg_regs.svh"
module hpbg_host_port #(
    parameter int DW = 32,
    parameter int AW = 32
) (
    input  wire logic                  SYS_CLK,
    input  wire logic                  RST,
    input  wire logic                  CE,
    input  wire hpbg_pkg::hpbg_width_type WIDTH_MODE,
    input  wire logic [1:0]            PORT_ACCESS_SELECT,
    input  wire logic                  HALFWORD_ORDER_SELECT,
    input  wire logic                  PORT_READ_WRITE,
    input  wire logic                  STROBE_INPUT_A,
    input  wire logic                  STROBE_INPUT_B,
    input  wire logic                  ADDR_STROBE_N,
    input  wire logic                  PORT_SELECT_N,
    input  wire logic                  LANE_ENABLE_LOW_N,
    input  wire logic                  LANE_ENABLE_HIGH_N,
    input  wire logic [DW-1:0]         PORT_DATA_LINES_IN,
    output logic      [DW-1:0]         PORT_DATA_LINES_OUT,
    output logic      [1:0]            PORT_DATA_LINES_OE,
    output logic                       PORT_READY_OUT_N,
    output logic                       PORT_INTERRUPT_OUT_N,
    input  wire logic                  DSP_INT_SET,
    output logic                       DSP_INT_PULSE,
    output logic                       MEM_REQ,
    output logic                       MEM_WE,
    output logic      [AW-1:0]         MEM_ADDR,
    output logic      [DW-1:0]         MEM_WDATA,
    output logic      [3:0]            MEM_BE,
    input  wire logic [DW-1:0]         MEM_RDATA,
    input  wire logic                  MEM_ACK
);
    import hpbg_pkg::*;

    localparam int HW = `HPBG_HALF_W;

    hpbg_state_type state_reg, state_next;
    logic [1:0]    sel_reg, sel_next;
    logic          rw_reg, rw_next, hw_reg, hw_next, served_reg, served_next;
    logic [1:0]    be_reg, be_next;
    logic [3:0]    wbe_reg, wbe_next;
    logic          order_reg, order_next, hflag_reg, hflag_next;
    logic [AW-1:0] addr_reg, addr_next;
    logic [DW-1:0] wbuf_reg, wbuf_next, rbuf_reg, rbuf_next, din_reg, din_next;
    logic [DW-1:0] dout_reg, dout_next;
    logic [1:0]    doe_reg, doe_next;
    logic          rdy_n_reg, rdy_n_next, dspint_reg, dspint_next;
    logic          mreq_reg, mreq_next, mwe_reg, mwe_next, inc_reg, inc_next, intn_reg, intn_next;
    logic [AW-1:0] maddr_reg, maddr_next;
    logic [DW-1:0] mwd_reg, mwd_next;
    logic          active, start, wide, upper, is_data, autoinc;
    logic [HW-1:0] ctrl_half;

    hpbg_strobe u_strobe (
        .clk      (SYS_CLK),
        .rst      (RST),
        .ce       (CE),
        .strobe_a (STROBE_INPUT_A),
        .strobe_b (STROBE_INPUT_B),
        .select_n (PORT_SELECT_N),
        .active   (active),
        .start    (start)
    );

    // Which half of a 32-bit word a 16-bit transfer touches
    function automatic logic half_upper(input logic hw, input logic order);
        half_upper = ~(hw ^ order);
    endfunction

    // Replace one half of a word, byte by byte under the lane enables
    function automatic logic [31:0] put_half(input logic [31:0] word, input logic up,
                                             input logic [15:0] val, input logic [1:0] be);
        logic [31:0] res;
        res = word;
        for (int b = 0; b < 2; b++) begin
            if (be[b] && up)
                res[16+8*b +: 8] = val[8*b +: 8];
            else if (be[b])
                res[8*b +: 8] = val[8*b +: 8];
        end
        put_half = res;
    endfunction

    function automatic logic [15:0] get_half(input logic [31:0] word, input logic up);
        get_half = up ? word[31:16] : word[15:0];
    endfunction

    // Read value for the latched select; 16-bit mode answers on the low half only
    function automatic logic [31:0] read_value(input logic [1:0] sel, input logic [31:0] data,
                                               input logic [31:0] addr, input logic [15:0] ctl,
                                               input logic wd, input logic up);
        logic [31:0] w;
        w = (sel == `HPBG_SEL_CTRL) ? {ctl, ctl} : (sel == `HPBG_SEL_ADDR) ? addr : data;
        read_value = wd ? w : {16'h0000, get_half(w, up)};
    endfunction

    always_comb begin
        wide       = (WIDTH_MODE == HPBG_FULL32);
        upper      = wide ? 1'b0 : half_upper(hw_reg, order_reg); // R02
        is_data    = sel_reg[1]; // R01
        autoinc    = (sel_reg == `HPBG_SEL_DATA_INC); // R01
        ctrl_half  = '0;
        ctrl_half[`HPBG_CTRL_ORDER]   = order_reg;
        ctrl_half[`HPBG_CTRL_HOSTINT] = hflag_reg;
        state_next = state_reg;
        sel_next   = sel_reg;
        rw_next    = rw_reg;
        hw_next    = hw_reg;
        be_next    = be_reg;
        wbe_next   = wbe_reg;
        served_next = served_reg;
        order_next = order_reg;
        hflag_next = hflag_reg;
        addr_next  = addr_reg;
        wbuf_next  = wbuf_reg;
        rbuf_next  = rbuf_reg;
        din_next   = active ? PORT_DATA_LINES_IN : din_reg;
        dout_next  = dout_reg;
        doe_next   = doe_reg;
        rdy_n_next = rdy_n_reg;
        dspint_next = 1'b0;
        mreq_next  = mreq_reg;
        mwe_next   = mwe_reg;
        maddr_next = maddr_reg;
        mwd_next   = mwd_reg;
        inc_next   = inc_reg;
        if (start) begin
            // Controls are taken once, at the leading edge of the strobe
            sel_next = PORT_ACCESS_SELECT; // R01
            hw_next  = HALFWORD_ORDER_SELECT; // R02
            rw_next  = PORT_READ_WRITE; // R03
            be_next  = {~LANE_ENABLE_HIGH_N, ~LANE_ENABLE_LOW_N};
        end
        case (state_reg)
            HPBG_IDLE: begin
                if (!active) begin
                    served_next = 1'b0;
                end else if (!served_reg && !start) begin
                    served_next = 1'b1;
                    // Only the first halfword of a data read goes to memory
                    if (rw_reg && is_data && (wide || !hw_reg)) begin // R02 R03
                        mreq_next  = 1'b1;
                        mwe_next   = 1'b0;
                        maddr_next = addr_reg;
                        state_next = HPBG_FETCH;
                    end else begin
                        dout_next  = read_value(sel_reg, rbuf_reg, addr_reg, ctrl_half,
                                                wide, upper);
                        doe_next   = rw_reg ? {wide, 1'b1} : 2'b00; // R03
                        rdy_n_next = 1'b0;
                        state_next = HPBG_HOLD;
                    end
                end
            end
            HPBG_FETCH: begin
                if (MEM_ACK) begin
                    mreq_next  = 1'b0;
                    rbuf_next  = MEM_RDATA;
                    addr_next  = autoinc ? addr_reg + `HPBG_ADDR_STEP : addr_reg;
                    dout_next  = read_value(sel_reg, MEM_RDATA, addr_reg, ctrl_half, wide, upper);
                    doe_next   = {wide, 1'b1};
                    rdy_n_next = 1'b0;
                    state_next = HPBG_HOLD;
                end
            end
            HPBG_HOLD: begin
                // Ready drops with the select so it cannot leak into the next cycle
                if (!active) begin // R08
                    rdy_n_next  = 1'b1;
                    doe_next    = 2'b00;
                    served_next = 1'b0;
                    state_next  = HPBG_IDLE;
                    if (!rw_reg) begin // R03
                        case (sel_reg) // R01
                            `HPBG_SEL_CTRL: begin
                                order_next = din_reg[`HPBG_CTRL_ORDER];
                                dspint_next = din_reg[`HPBG_CTRL_DSPINT];
                                if (din_reg[`HPBG_CTRL_HOSTINT])
                                    hflag_next = 1'b0;
                            end
                            `HPBG_SEL_ADDR: begin
                                addr_next = wide ? din_reg :
                                            put_half(addr_reg, upper, din_reg[HW-1:0], 2'b11);
                            end
                            default: begin
                                if (wide) begin
                                    wbuf_next = din_reg;
                                    wbe_next  = {be_reg, be_reg};
                                end else begin
                                    wbuf_next = put_half(wbuf_reg, upper, din_reg[HW-1:0], be_reg);
                                    wbe_next  = upper ? {be_reg, wbe_reg[1:0]} :
                                                        {wbe_reg[3:2], be_reg};
                                end
                                // 16-bit writes reach memory on the second halfword
                                if (wide || hw_reg) begin // R02
                                    mreq_next  = 1'b1;
                                    mwe_next   = 1'b1;
                                    maddr_next = addr_reg;
                                    mwd_next   = wbuf_next;
                                    // Kept apart: the next access may relatch the select mid-store
                                    inc_next   = autoinc; // R01
                                    state_next = HPBG_STORE;
                                end
                            end
                        endcase
                    end
                end
            end
            HPBG_STORE: begin
                if (MEM_ACK) begin
                    mreq_next  = 1'b0;
                    mwe_next   = 1'b0;
                    addr_next  = inc_reg ? addr_reg + `HPBG_ADDR_STEP : addr_reg;
                    state_next = HPBG_IDLE;
                end
            end
            default: state_next = HPBG_IDLE;
        endcase
        // A core request in the same cycle as the host clear wins
        if (DSP_INT_SET)
            hflag_next = 1'b1;
        intn_next = ~hflag_next;
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_reg <= HPBG_IDLE;
            sel_reg   <= `HPBG_SEL_CTRL;
            rw_reg    <= 1'b1;
            hw_reg    <= 1'b0;
            be_reg    <= 2'b00;
            wbe_reg   <= 4'h0;
            served_reg <= 1'b0;
            order_reg <= 1'b0;
            hflag_reg <= 1'b0;
            addr_reg  <= `HPBG_ADDR_RESET;
            wbuf_reg  <= '0;
            rbuf_reg  <= '0;
            din_reg   <= '0;
            dout_reg  <= '0;
            doe_reg   <= 2'b00;
            rdy_n_reg <= 1'b1;
            dspint_reg <= 1'b0;
            mreq_reg  <= 1'b0;
            mwe_reg   <= 1'b0;
            maddr_reg <= '0;
            mwd_reg   <= '0;
            inc_reg   <= 1'b0;
            intn_reg  <= 1'b1;
        end else if (CE) begin
            state_reg <= state_next;
            sel_reg   <= sel_next;
            rw_reg    <= rw_next;
            hw_reg    <= hw_next;
            be_reg    <= be_next;
            wbe_reg   <= wbe_next;
            served_reg <= served_next;
            order_reg <= order_next;
            hflag_reg <= hflag_next;
            addr_reg  <= addr_next;
            wbuf_reg  <= wbuf_next;
            rbuf_reg  <= rbuf_next;
            din_reg   <= din_next;
            dout_reg  <= dout_next;
            doe_reg   <= doe_next;
            rdy_n_reg <= rdy_n_next;
            dspint_reg <= dspint_next;
            mreq_reg  <= mreq_next;
            mwe_reg   <= mwe_next;
            maddr_reg <= maddr_next;
            mwd_reg   <= mwd_next;
            inc_reg   <= inc_next;
            intn_reg  <= intn_next;
        end
    end

    assign PORT_DATA_LINES_OUT  = dout_reg;
    assign PORT_DATA_LINES_OE   = doe_reg;
    assign PORT_READY_OUT_N     = rdy_n_reg;
    assign PORT_INTERRUPT_OUT_N = intn_reg;
    assign DSP_INT_PULSE        = dspint_reg;
    assign MEM_REQ              = mreq_reg;
    assign MEM_WE               = mwe_reg;
    assign MEM_ADDR             = maddr_reg;
    assign MEM_WDATA            = mwd_reg;
    assign MEM_BE               = wbe_reg;

    ctrl_select_a : assert property (@(posedge SYS_CLK) disable iff (RST || !CE) // R01
        (state_reg == HPBG_HOLD && !active && !rw_reg && sel_reg == `HPBG_SEL_CTRL)
        |=> order_reg == $past(din_reg[`HPBG_CTRL_ORDER]))
        else $error("control write did not reach the order bit");
    second_half_a : assert property (@(posedge SYS_CLK) disable iff (RST || !CE) // R02
        (state_reg == HPBG_IDLE && active && !served_reg && !start && rw_reg
         && is_data && !wide && hw_reg) |=> (state_reg == HPBG_HOLD && !mreq_reg))
        else $error("second halfword read went to memory");
    read_drive_a : assert property (@(posedge SYS_CLK) disable iff (RST || !CE) // R03
        (doe_reg != 2'b00) |-> (rw_reg && state_reg == HPBG_HOLD))
        else $error("data lines driven outside a read");
    ready_release_a : assert property (@(posedge SYS_CLK) disable iff (RST || !CE) // R08
        (PORT_SELECT_N)[*2] |=> PORT_READY_OUT_N)
        else $error("ready held after select negated");
endmodule

// File: bench/hpbg_host_model.sv
// Host bus master model driving the host port pins
`timescale 1ns/1ns
module hpbg_host_model (
    input  wire logic                     clk,
    input  wire hpbg_pkg::hpbg_width_type width_mode,
    input  wire logic                     bad_strobe,
    input  wire logic [31:0]              port_out,
    input  wire logic                     ready_n,
    output logic      [1:0]               access_select,
    output logic                          half_select,
    output logic                          read_write,
    output logic                          strobe_a,
    output logic                          strobe_b,
    output logic                          addr_strobe_n,
    output logic                          select_n,
    output logic                          lane_low_n,
    output logic                          lane_high_n,
    output logic      [31:0]              port_in
);
    import hpbg_pkg::*;
    logic [31:0] host_d = 32'h0;
    logic        ack_n;
    logic [2:0]  config_strap;
    logic        auto_vector_n;
    initial begin
        access_select = 2'h0;
        half_select = 1'b0;
        read_write = 1'b1;
        select_n = 1'b1;
    end
    assign ack_n = ready_n | select_n;
    assign strobe_a = bad_strobe;
    assign strobe_b = 1'b1;
    assign addr_strobe_n = 1'b1;
    assign lane_low_n = 1'b0;
    assign lane_high_n = 1'b0;
    // Strap levels of the host; both keep its core enabled
    assign config_strap = (width_mode == HPBG_HALF16) ? 3'h5 : 3'h4;
    assign auto_vector_n = 1'b0;
    // Narrow port rides on the upper host lines; the unused half keeps toggling
    assign port_in = (width_mode == HPBG_HALF16) ? {~host_d[15:0], host_d[31:16]} : host_d;
    task automatic cycle(input logic [1:0] sel, input logic hw, input logic rw,
                         input logic [31:0] wd, input int limit,
                         output logic [31:0] rd, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        rd = 32'h0;
        @(negedge clk);
        access_select = sel;
        half_select = hw;
        read_write = rw;
        host_d = rw ? ~host_d : wd;
        select_n = 1'b0;
        while (!ok && n < limit) begin
            @(negedge clk);
            n++;
            if (ack_n === 1'b0) begin
                ok = 1'b1;
                rd = (width_mode == HPBG_HALF16) ? {port_out[15:0], 16'h0} : port_out;
            end
        end
        // Write data stands past the select negation: the port keeps the last value it samples
        select_n = 1'b1;
        n = 0;
        while (ready_n !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        host_d = ~host_d;
        repeat (2) @(negedge clk);
    endtask
endmodule

// File: bench/tb_top.sv
// Self-checking bench of the host port glue
`timescale 1ns/1ns
`include "hpbg_regs.svh"
`define CHECK(nm, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) begin \
            n_errors++; \
            $display("ERROR %s expected %h seen %h", nm, exp, got); \
        end \
    end
module tb_top;
    import hpbg_pkg::*;
    logic           SYS_CLK = 1'b0;
    logic           RST = 1'b1;
    hpbg_width_type WIDTH_MODE = HPBG_FULL32;
    logic           bad_strobe = 1'b0;
    logic           DSP_INT_SET = 1'b0;
    logic           MEM_ACK = 1'b0;
    logic           CE = 1'b1;
    logic [31:0]    MEM_RDATA = 32'h0;
    logic [1:0]     sel_w, oe;
    logic           hw_w, rw_w, sa, sb, as_n, cs_n, ll_n, lh_n, rdy_n, int_n, pulse;
    logic           MEM_REQ, MEM_WE;
    logic [31:0]    din, dout, MEM_ADDR, MEM_WDATA, rd;
    logic [3:0]     MEM_BE;
    logic [31:0]    mem [0:63];
    int             mem_delay = 0;
    int             mem_wait = 0;
    int             cycles = 0;
    int             pulses = 0;
    int             n_errors = 0;
    int             num_checks = 0;
    logic           req_seen = 1'b0;
    always #2 SYS_CLK = ~SYS_CLK;
    hpbg_host_port uut (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .WIDTH_MODE(WIDTH_MODE),
        .PORT_ACCESS_SELECT(sel_w), .HALFWORD_ORDER_SELECT(hw_w), .PORT_READ_WRITE(rw_w),
        .STROBE_INPUT_A(sa), .STROBE_INPUT_B(sb), .ADDR_STROBE_N(as_n), .PORT_SELECT_N(cs_n),
        .LANE_ENABLE_LOW_N(ll_n), .LANE_ENABLE_HIGH_N(lh_n), .PORT_DATA_LINES_IN(din),
        .PORT_DATA_LINES_OUT(dout), .PORT_DATA_LINES_OE(oe), .PORT_READY_OUT_N(rdy_n),
        .PORT_INTERRUPT_OUT_N(int_n), .DSP_INT_SET(DSP_INT_SET), .DSP_INT_PULSE(pulse),
        .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
        .MEM_BE(MEM_BE), .MEM_RDATA(MEM_RDATA), .MEM_ACK(MEM_ACK));
    hpbg_host_model host (.clk(SYS_CLK), .width_mode(WIDTH_MODE), .bad_strobe(bad_strobe),
        .port_out(dout), .ready_n(rdy_n), .access_select(sel_w), .half_select(hw_w),
        .read_write(rw_w), .strobe_a(sa), .strobe_b(sb), .addr_strobe_n(as_n),
        .select_n(cs_n), .lane_low_n(ll_n), .lane_high_n(lh_n), .port_in(din));
    // Memory answers after mem_delay cycles; read data churns while not acknowledged
    always @(negedge SYS_CLK) begin
        if (MEM_REQ === 1'b1 && !MEM_ACK && mem_wait >= mem_delay) begin
            MEM_ACK = 1'b1;
            mem_wait = 0;
            for (int b = 0; b < 4; b++) begin
                if (MEM_WE && MEM_BE[b])
                    mem[MEM_ADDR[7:2]][8*b +: 8] = MEM_WDATA[8*b +: 8];
            end
            MEM_RDATA = mem[MEM_ADDR[7:2]];
        end else begin
            if (MEM_REQ === 1'b1 && !MEM_ACK)
                mem_wait++;
            MEM_ACK = 1'b0;
            MEM_RDATA = ~MEM_RDATA;
        end
    end
    always @(posedge SYS_CLK) begin
        cycles++;
        if (MEM_REQ === 1'b1)
            req_seen = 1'b1;
        if (pulse === 1'b1)
            pulses++;
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic do_reset(input hpbg_width_type m);
        @(negedge SYS_CLK);
        RST = 1'b1;
        WIDTH_MODE = m;
        repeat (16) @(negedge SYS_CLK);
        RST = 1'b0;
        repeat (2) @(negedge SYS_CLK);
    endtask
    task automatic acc(input logic [1:0] sel, input logic hw, input logic rw,
                       input logic [31:0] wd);
        logic ok;
        host.cycle(sel, hw, rw, wd, 200, rd, ok);
        `CHECK("acknowledge", 1'b1, ok)
    endtask
    task automatic t_reset();
        `CHECK("ready idle", 1'b1, rdy_n)
        `CHECK("drive enables", 2'b00, oe)
        `CHECK("interrupt idle", 1'b1, int_n)
        `CHECK("memory idle", 1'b0, MEM_REQ)
        `CHECK("wide strap", 3'h4, host.config_strap)
        `CHECK("core strap", 2'h2, host.config_strap[2:1])
        `CHECK("auto vector", 1'b0, host.auto_vector_n)
        $display("test reset done");
    endtask
    task automatic t_word32();
        mem_delay = 4;
        acc(`HPBG_SEL_ADDR, 1'b0, 1'b0, 32'h0000_0010);
        acc(`HPBG_SEL_DATA_FIX, 1'b0, 1'b0, 32'ha5a5_1234);
        acc(`HPBG_SEL_DATA_FIX, 1'b0, 1'b1, 32'h0);
        `CHECK("read word", 32'ha5a5_1234, rd)
        `CHECK("stored word", 32'ha5a5_1234, mem[4])
        acc(`HPBG_SEL_DATA_FIX, 1'b0, 1'b1, 32'h0);
        `CHECK("fixed reread", 32'ha5a5_1234, rd)
        $display("test word32 done");
    endtask
    task automatic t_autoinc();
        mem_delay = 0;
        mem[10] = 32'h3333_3333;
        acc(`HPBG_SEL_ADDR, 1'b0, 1'b0, 32'h0000_0020);
        acc(`HPBG_SEL_DATA_INC, 1'b0, 1'b0, 32'h1111_1111);
        acc(`HPBG_SEL_DATA_INC, 1'b0, 1'b0, 32'h2222_2222);
        acc(`HPBG_SEL_ADDR, 1'b0, 1'b0, 32'h0000_0020);
        acc(`HPBG_SEL_DATA_INC, 1'b0, 1'b1, 32'h0);
        `CHECK("inc read 0", 32'h1111_1111, rd)
        acc(`HPBG_SEL_DATA_INC, 1'b0, 1'b1, 32'h0);
        `CHECK("inc read 1", 32'h2222_2222, rd)
        acc(`HPBG_SEL_DATA_FIX, 1'b0, 1'b1, 32'h0);
        `CHECK("after inc", 32'h3333_3333, rd)
        $display("test autoinc done");
    endtask
    task automatic t_refuse();
        logic ok;
        bad_strobe = 1'b1;
        req_seen = 1'b0;
        host.cycle(`HPBG_SEL_DATA_FIX, 1'b0, 1'b1, 32'h0, 12, rd, ok);
        `CHECK("refused ack", 1'b0, ok)
        `CHECK("refused fetch", 1'b0, req_seen)
        bad_strobe = 1'b0;
        $display("test refuse done");
    endtask
    task automatic t_irq();
        CE = 1'b0;
        DSP_INT_SET = 1'b1;
        @(negedge SYS_CLK);
        DSP_INT_SET = 1'b0;
        repeat (2) @(negedge SYS_CLK);
        `CHECK("frozen flag", 1'b1, int_n)
        CE = 1'b1;
        @(negedge SYS_CLK);
        DSP_INT_SET = 1'b1;
        @(negedge SYS_CLK);
        DSP_INT_SET = 1'b0;
        repeat (2) @(negedge SYS_CLK);
        `CHECK("flag raised", 1'b0, int_n)
        acc(`HPBG_SEL_CTRL, 1'b0, 1'b1, 32'h0);
        `CHECK("flag read", 1'b1, rd[`HPBG_CTRL_HOSTINT])
        acc(`HPBG_SEL_CTRL, 1'b0, 1'b0, 32'h0000_0004);
        `CHECK("flag cleared", 1'b1, int_n)
        pulses = 0;
        acc(`HPBG_SEL_CTRL, 1'b0, 1'b0, 32'h0000_0002);
        repeat (2) @(negedge SYS_CLK);
        `CHECK("core pulse", 1, pulses)
        $display("test irq done");
    endtask
    task automatic t_half16();
        mem_delay = 2;
        acc(`HPBG_SEL_CTRL, 1'b0, 1'b0, 32'h0);
        acc(`HPBG_SEL_ADDR, 1'b0, 1'b0, 32'h0);
        acc(`HPBG_SEL_ADDR, 1'b1, 1'b0, 32'h0030_0000);
        acc(`HPBG_SEL_DATA_FIX, 1'b0, 1'b0, 32'hbeef_0000);
        acc(`HPBG_SEL_DATA_FIX, 1'b1, 1'b0, 32'hcafe_0000);
        acc(`HPBG_SEL_DATA_FIX, 1'b0, 1'b1, 32'h0);
        `CHECK("first half", 16'hbeef, rd[31:16])
        acc(`HPBG_SEL_DATA_FIX, 1'b1, 1'b1, 32'h0);
        `CHECK("second half", 16'hcafe, rd[31:16])
        `CHECK("half word", 32'hbeef_cafe, mem[12])
        `CHECK("drive released", 2'b00, oe)
        `CHECK("narrow strap", 3'h5, host.config_strap)
        $display("test half16 done");
    endtask
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = 32'h0;
        end
        do_reset(HPBG_FULL32);
        t_reset();
        t_word32();
        t_autoinc();
        t_refuse();
        t_irq();
        do_reset(HPBG_HALF16);
        t_half16();
        finish_test();
    end
endmodule
